// file: logic/ppsp_pin_select.sv
`include "ppsp_map.svh"

// Function
// - i2c enable routes two port 3 pins to i2c clock and data.
// - threshold enable bits connect port 1 lines 0-2 to threshold channels.
// - select register bits 7-5 and 3 carry no function.
// - port 0 line without pwm: writes hit latch, reads latch or pin.
// - port 1 is four lines, or three threshold inputs and pwm 0.
// - pwm on port 1 line 3 only when channel 0 enable set.
// - port 3 lines 5/4 are i2c data/clock only with latch and enable.
// - port 3 line 3 is timer one input with latch and enable.
// - port 3 line 2 is ext irq a input with latch and enable.
// - port 3 line 1 is timer zero input with latch and enable.
// - port 3 line 0 is ext irq b input with latch and enable.
// - port 3 lines 6 and 7 are always plain port lines.
// - nine pwm channels, each with its own register.
// - each pwm pattern repeats every 128 pwm clock periods.
// - high time equals duty value; pwm clock is crystal over four.
// - pwm output is active high, never inverted.
// - register bit 7 enables pin drive, bits 6-0 hold duty.
// - port 0 has eight lines, line n can carry pwm n+1 (pwm 1-8).
module ppsp_pin_select #(
    parameter int PWM_DIV = `PPSP_PWM_DIV,
    parameter int NUM_PWM = 9
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire ppsp_pkg::ppsp_sfr_t sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_rmw,
    input wire ppsp_pkg::ppsp_sfr_t sfr_wdata,
    output ppsp_pkg::ppsp_sfr_t sfr_rdata,
    output logic sfr_hit,
    input wire logic [7:0] p0_pin_in,
    output logic [7:0] p0_pin_out,
    output logic [7:0] p0_pin_oe_n,
    input wire logic [3:0] p1_pin_in,
    output logic [3:0] p1_pin_out,
    output logic [3:0] p1_pin_oe_n,
    input wire logic [7:0] p3_pin_in,
    output logic [7:0] p3_pin_out,
    output logic [7:0] p3_pin_oe_n,
    input wire logic timer_zero_irq_enable,
    input wire logic timer_one_irq_enable,
    input wire logic ext_irq_a_enable,
    input wire logic ext_irq_b_enable,
    input wire logic i2c_scl_drive_low,
    input wire logic i2c_sda_drive_low,
    output logic i2c_scl_in,
    output logic i2c_sda_in,
    output logic timer_zero_count_input,
    output logic timer_one_count_input,
    output logic ext_irq_a_pin,
    output logic ext_irq_b_pin,
    output logic threshold_input_a,
    output logic threshold_input_b,
    output logic threshold_input_c
);
    localparam ppsp_pkg::ppsp_sfr_t PWM_ADDR [NUM_PWM] = '{
        `PPSP_ADDR_PWM_LEVEL_0, `PPSP_ADDR_PWM_LEVEL_1, `PPSP_ADDR_PWM_LEVEL_2,
        `PPSP_ADDR_PWM_LEVEL_3, `PPSP_ADDR_PWM_LEVEL_4, `PPSP_ADDR_PWM_LEVEL_5,
        `PPSP_ADDR_PWM_LEVEL_6, `PPSP_ADDR_PWM_LEVEL_7, `PPSP_ADDR_PWM_LEVEL_8
    };

    ppsp_pkg::ppsp_sfr_t port0_pin_latch;
    logic [3:0] port1_pin_latch;
    ppsp_pkg::ppsp_sfr_t port3_pin_latch;
    ppsp_pkg::ppsp_sfr_t port1_function_select;
    ppsp_pkg::ppsp_sfr_t pwm_level [NUM_PWM];
    logic [NUM_PWM-1:0] pwm_wave;
    logic [NUM_PWM-1:0] pwm_output_enable;
    logic [NUM_PWM-1:0] pwm_wr;
    logic [7:0] p0_sync;
    logic [3:0] p1_sync;
    logic [7:0] p3_sync;
    logic [1:0] prescale;
    logic pwm_tick;
    ppsp_pkg::ppsp_duty_t pwm_count;
    ppsp_pkg::ppsp_sfr_t next_rdata;
    logic next_hit;
    ppsp_pkg::ppsp_rdsrc_t rd_src;
    logic i2c_pin_enable;
    logic scl_route;
    logic sda_route;
    logic t0_route;
    logic t1_route;
    logic xa_route;
    logic xb_route;

    // ==========================================================
    // pin synchronisers
    ppsp_sync #(.WIDTH(8)) u_sync_p0 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(p0_pin_in),
        .dout(p0_sync)
    );
    ppsp_sync #(.WIDTH(4)) u_sync_p1 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(p1_pin_in),
        .dout(p1_sync)
    );
    ppsp_sync #(.WIDTH(8)) u_sync_p3 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(p3_pin_in),
        .dout(p3_sync)
    );

    // ==========================================================
    // pwm clock: crystal over four, shared 7-bit counter
    assign pwm_tick = prescale == 2'(PWM_DIV - 1);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prescale <= 2'h0;
        end else begin
            prescale <= pwm_tick ? 2'h0 : prescale + 2'h1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_count <= 7'h00;
        end else if (pwm_tick) begin
            pwm_count <= pwm_count + 7'h01;
        end
    end

    // ==========================================================
    // pwm channels
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PWM; gi++) begin : g_pwm
            assign pwm_wr[gi] = sfr_wr && sfr_addr == PWM_ADDR[gi];
            assign pwm_output_enable[gi] = pwm_level[gi][`PPSP_BIT_PWM_EN];
            ppsp_pwm_channel u_chan (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .wr_en(pwm_wr[gi]),
                .wdata(sfr_wdata),
                .tick(pwm_tick),
                .count(pwm_count),
                .level(pwm_level[gi]),
                .pwm_out(pwm_wave[gi])
            );
        end
    endgenerate

    // ==========================================================
    // port latches and select register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            port0_pin_latch <= `PPSP_RST_PORT0;
        end else if (sfr_wr && sfr_addr == `PPSP_ADDR_PORT0) begin
            port0_pin_latch <= sfr_wdata;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            port1_pin_latch <= `PPSP_RST_PORT1;
        end else if (sfr_wr && sfr_addr == `PPSP_ADDR_PORT1) begin
            port1_pin_latch <= sfr_wdata[3:0];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            port3_pin_latch <= `PPSP_RST_PORT3;
        end else if (sfr_wr && sfr_addr == `PPSP_ADDR_PORT3) begin
            port3_pin_latch <= sfr_wdata;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            port1_function_select <= `PPSP_RST_PORT1_FUNCTION_SELECT;
        end else if (sfr_wr && sfr_addr == `PPSP_ADDR_PORT1_FUNCTION_SELECT) begin
            port1_function_select <= sfr_wdata & `PPSP_PORT1_FUNCTION_SELECT_WMASK;
        end
    end

    // ==========================================================
    // register read
    always_comb begin
        next_rdata = 8'h00;
        next_hit = 1'b0;
        rd_src = sfr_rmw ? ppsp_pkg::PPSP_RD_LATCH : ppsp_pkg::PPSP_RD_PIN;
        case (sfr_addr)
            `PPSP_ADDR_PORT0: begin
                next_hit = 1'b1;
                next_rdata = (rd_src == ppsp_pkg::PPSP_RD_LATCH) ? port0_pin_latch : p0_sync;
            end
            `PPSP_ADDR_PORT1: begin
                next_hit = 1'b1;
                next_rdata = {4'h0,
                    (rd_src == ppsp_pkg::PPSP_RD_LATCH) ? port1_pin_latch : p1_sync};
            end
            `PPSP_ADDR_PORT3: begin
                next_hit = 1'b1;
                next_rdata = (rd_src == ppsp_pkg::PPSP_RD_LATCH) ? port3_pin_latch : p3_sync;
            end
            `PPSP_ADDR_PORT1_FUNCTION_SELECT: begin
                next_hit = 1'b1;
                next_rdata = port1_function_select;
            end
            default: begin
                rd_src = ppsp_pkg::PPSP_RD_NONE;
            end
        endcase
        for (int i = 0; i < NUM_PWM; i++) begin
            if (sfr_addr == PWM_ADDR[i]) begin
                next_hit = 1'b1;
                next_rdata = pwm_level[i];
            end
        end
    end

    assign sfr_hit = next_hit;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= next_rdata;
        end
    end

    // ==========================================================
    // port 0 pins: eight lines or pwm 1-8
    generate
        for (gi = 0; gi < 8; gi++) begin : g_p0
            assign p0_pin_out[gi] = pwm_output_enable[gi+1] & pwm_wave[gi+1];
            assign p0_pin_oe_n[gi] = pwm_output_enable[gi+1] ? 1'b0 : port0_pin_latch[gi];
        end
    endgenerate

    // ==========================================================
    // port 1 pins: threshold inputs and pwm 0
    generate
        for (gi = 0; gi < 3; gi++) begin : g_p1
            assign p1_pin_out[gi] = 1'b0;
            assign p1_pin_oe_n[gi] = port1_function_select[gi] | port1_pin_latch[gi];
        end
    endgenerate

    assign p1_pin_out[`PPSP_P1_PWM_LINE] = pwm_output_enable[0] & pwm_wave[0];
    assign p1_pin_oe_n[`PPSP_P1_PWM_LINE] = pwm_output_enable[0] ? 1'b0 :
        port1_pin_latch[`PPSP_P1_PWM_LINE];

    assign threshold_input_a = port1_function_select[`PPSP_BIT_THR_A];
    assign threshold_input_b = port1_function_select[`PPSP_BIT_THR_B];
    assign threshold_input_c = port1_function_select[`PPSP_BIT_THR_C];

    // ==========================================================
    // port 3 pins: i2c, timer and interrupt inputs
    assign i2c_pin_enable = port1_function_select[`PPSP_BIT_I2C_EN];
    assign scl_route = i2c_pin_enable & port3_pin_latch[4];
    assign sda_route = i2c_pin_enable & port3_pin_latch[5];
    assign t0_route = port3_pin_latch[1] & timer_zero_irq_enable;
    assign t1_route = port3_pin_latch[3] & timer_one_irq_enable;
    assign xa_route = port3_pin_latch[2] & ext_irq_a_enable;
    assign xb_route = port3_pin_latch[0] & ext_irq_b_enable;

    assign p3_pin_out = 8'h00;
    assign p3_pin_oe_n = {port3_pin_latch[7:6],
        sda_route ? ~i2c_sda_drive_low : port3_pin_latch[5],
        scl_route ? ~i2c_scl_drive_low : port3_pin_latch[4],
        port3_pin_latch[3:0]};

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            i2c_scl_in <= 1'b1;
            i2c_sda_in <= 1'b1;
        end else begin
            i2c_scl_in <= scl_route ? p3_sync[4] : 1'b1;
            i2c_sda_in <= sda_route ? p3_sync[5] : 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_zero_count_input <= 1'b0;
            timer_one_count_input <= 1'b0;
            ext_irq_a_pin <= 1'b1;
            ext_irq_b_pin <= 1'b1;
        end else begin
            timer_zero_count_input <= t0_route ? p3_sync[1] : 1'b0;
            timer_one_count_input <= t1_route ? p3_sync[3] : 1'b0;
            ext_irq_a_pin <= xa_route ? p3_sync[2] : 1'b1;
            ext_irq_b_pin <= xb_route ? p3_sync[0] : 1'b1;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    AST_I2C_SCL: assert property (scl_route |-> p3_pin_oe_n[4] == !i2c_scl_drive_low)
        else $error("scl pin not following i2c core");
    AST_I2C_OFF: assert property (!i2c_pin_enable |->
        p3_pin_oe_n[5:4] == port3_pin_latch[5:4]
        && ($past(i2c_pin_enable) || (i2c_sda_in && i2c_scl_in)))
        else $error("i2c lines routed while disabled");
    AST_THRESHOLD: assert property (port1_function_select[0] |->
        p1_pin_oe_n[0] && threshold_input_a)
        else $error("threshold pin still driven");
    AST_RESERVED: assert property (1'b1 |->
        (port1_function_select & ~`PPSP_PORT1_FUNCTION_SELECT_WMASK) == 8'h00)
        else $error("reserved select bits hold a value");
    AST_P0_WRITE: assert property (sfr_wr && sfr_addr == `PPSP_ADDR_PORT0
        && !pwm_output_enable[1] |=> p0_pin_oe_n[0] == $past(sfr_wdata[0]))
        else $error("port 0 write did not reach the pin");
    AST_PWM_LEVEL_0_OFF: assert property (!pwm_output_enable[0] |->
        p1_pin_oe_n[3] == port1_pin_latch[3] && !p1_pin_out[3])
        else $error("pwm 0 drives pin while disabled");
    AST_TIMER1: assert property ($past(t1_route) |->
        timer_one_count_input == $past(p3_pin_in[3], 3))
        else $error("timer one input not following pin");
    AST_EXT_A: assert property ($past(xa_route) |->
        ext_irq_a_pin == $past(p3_pin_in[2], 3))
        else $error("ext irq a input not following pin");
    AST_TIMER0: assert property ($past(t0_route) |->
        timer_zero_count_input == $past(p3_pin_in[1], 3))
        else $error("timer zero input not following pin");
    AST_EXT_B: assert property ($past(xb_route) |->
        ext_irq_b_pin == $past(p3_pin_in[0], 3))
        else $error("ext irq b input not following pin");
    AST_PLAIN_LINES: assert property (p3_pin_oe_n[7:6] == port3_pin_latch[7:6])
        else $error("port 3 upper lines not plain");
    AST_PERIOD: assert property ((pwm_tick && pwm_count == 7'h7f) |=>
        pwm_count == 7'h00 ##0 !pwm_tick [*3] ##1 pwm_tick)
        else $error("pwm frame length wrong");
    AST_PWM_PIN: assert property (pwm_output_enable[8] |->
        !p0_pin_oe_n[7] && p0_pin_out[7] == pwm_wave[8])
        else $error("pwm 8 not on port 0 line 7");

    COV_I2C: cover property (scl_route && sda_route && i2c_scl_drive_low);
    COV_PWM_LEVEL_0: cover property (pwm_output_enable[0] && p1_pin_out[3]);
    COV_EXT_B: cover property (xb_route ##1 !ext_irq_b_pin);
endmodule // ppsp_pin_select

// file: logic/ppsp_map.svh
`ifndef PPSP_MAP_SVH
`define PPSP_MAP_SVH

// ==========================================================
// register addresses
`define PPSP_ADDR_PORT0 8'h80
`define PPSP_ADDR_PORT1 8'h90
`define PPSP_ADDR_PORT3 8'hb0
`define PPSP_ADDR_PORT1_FUNCTION_SELECT 8'hf4
`define PPSP_ADDR_PWM_LEVEL_0 8'h86
`define PPSP_ADDR_PWM_LEVEL_1 8'h96
`define PPSP_ADDR_PWM_LEVEL_2 8'ha6
`define PPSP_ADDR_PWM_LEVEL_3 8'hb6
`define PPSP_ADDR_PWM_LEVEL_4 8'hc6
`define PPSP_ADDR_PWM_LEVEL_5 8'hd6
`define PPSP_ADDR_PWM_LEVEL_6 8'he6
`define PPSP_ADDR_PWM_LEVEL_7 8'hf6
`define PPSP_ADDR_PWM_LEVEL_8 8'hf5

// ==========================================================
// reset values
`define PPSP_RST_PORT0 8'hff
`define PPSP_RST_PORT1 4'hf
`define PPSP_RST_PORT3 8'hff
`define PPSP_RST_PORT1_FUNCTION_SELECT 8'h00
`define PPSP_RST_PWM 8'h00

// ==========================================================
// field positions
`define PPSP_BIT_THR_A 0
`define PPSP_BIT_THR_B 1
`define PPSP_BIT_THR_C 2
`define PPSP_BIT_I2C_EN 4
`define PPSP_PORT1_FUNCTION_SELECT_WMASK 8'h17
`define PPSP_BIT_PWM_EN 7
`define PPSP_P1_PWM_LINE 3

// ==========================================================
// timing
`define PPSP_PWM_DIV 4
`define PPSP_PWM_PERIOD 128

`endif

// file: logic/ppsp_pkg.sv
package ppsp_pkg;
    typedef logic [7:0] ppsp_sfr_t;
    typedef logic [6:0] ppsp_duty_t;
    typedef enum logic [2:0] {
        PPSP_RD_PIN = 3'b001,
        PPSP_RD_LATCH = 3'b010,
        PPSP_RD_NONE = 3'b100
    } ppsp_rdsrc_t;
endpackage

// file: logic/ppsp_sync.sv
// ==========================================================
// two-stage pin synchroniser
module ppsp_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= '1;
            dout <= '1;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // ppsp_sync

// file: logic/ppsp_pwm_channel.sv
`include "ppsp_map.svh"

// ==========================================================
// one pwm channel: level register and comparator
module ppsp_pwm_channel (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire ppsp_pkg::ppsp_sfr_t wdata,
    input wire logic tick,
    input wire ppsp_pkg::ppsp_duty_t count,
    output ppsp_pkg::ppsp_sfr_t level,
    output logic pwm_out
);
    ppsp_pkg::ppsp_duty_t active;
    ppsp_pkg::ppsp_duty_t next_active;
    logic next_out;
    logic [7:0] high_cnt;

    // ==========================================================
    // level register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            level <= `PPSP_RST_PWM;
        end else if (wr_en) begin
            level <= wdata;
        end
    end

    // ==========================================================
    // duty taken at frame start, high while count below duty
    always_comb begin
        next_active = (count == 7'h00) ? level[6:0] : active;
        next_out = count < next_active;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            active <= 7'h00;
            pwm_out <= 1'b0;
        end else if (tick) begin
            active <= next_active;
            pwm_out <= next_out;
        end
    end

    // ==========================================================
    // checks
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            high_cnt <= 8'h00;
        end else if (tick) begin
            high_cnt <= (count == 7'h00) ? {7'h00, next_out} : high_cnt + {7'h00, next_out};
        end
    end

    AST_HIGH_TIME: assert property (@(posedge mclk) disable iff (sys_rst)
        (tick && count == 7'h7f) |=> high_cnt == {1'b0, active})
        else $error("pwm high time differs from duty");
    AST_OUT_STABLE: assert property (@(posedge mclk) disable iff (sys_rst)
        !tick |=> $stable(pwm_out))
        else $error("pwm output moved between pwm clock ticks");
    COV_FULL_DUTY: cover property (@(posedge mclk) disable iff (sys_rst)
        tick && count == 7'h7f && active == 7'h7f);
endmodule // ppsp_pwm_channel

// file: verification/ppsp_board.sv
// ==========================================================
// board side of one port: pull-ups and parts pulling pins low
module ppsp_board #(
    parameter int W = 8
) (
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe_n,
    input wire logic [W-1:0] ext_low,
    output logic [W-1:0] level
);
    timeunit 1ns;
    timeprecision 100ps;
    // released lines float up to the pull-up
    always_comb begin
        for (int i = 0; i < W; i++) begin
            level[i] = !pin_oe_n[i] ? pin_out[i] : !ext_low[i];
        end
    end
endmodule // ppsp_board

// file: verification/tb_top.sv
`include "ppsp_map.svh"

// ==========================================================
// testbench top
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, sys_rst, sfr_wr, sfr_rd, sfr_rmw, sfr_hit;
    ppsp_pkg::ppsp_sfr_t sfr_addr, sfr_wdata, sfr_rdata;
    logic [7:0] p0_out, p0_oe_n, p0_ext_low, p0_lvl, p3_out, p3_oe_n, p3_ext_low, p3_lvl;
    logic [3:0] p1_out, p1_oe_n, p1_ext_low, p1_lvl, en, fo;
    logic scl_low, sda_low, scl_in, sda_in;
    logic [2:0] thr;
    logic [7:0] rv;
    logic [15:0] hi[9];
    int n_fail = 0;
    int checks_done = 0;
    logic [7:0] pwm_addr[9] = '{`PPSP_ADDR_PWM_LEVEL_0, `PPSP_ADDR_PWM_LEVEL_1, `PPSP_ADDR_PWM_LEVEL_2,
        `PPSP_ADDR_PWM_LEVEL_3, `PPSP_ADDR_PWM_LEVEL_4, `PPSP_ADDR_PWM_LEVEL_5, `PPSP_ADDR_PWM_LEVEL_6,
        `PPSP_ADDR_PWM_LEVEL_7, `PPSP_ADDR_PWM_LEVEL_8};
    logic [6:0] duty[9] = '{7'h00, 7'h01, 7'h02, 7'h05, 7'h3f, 7'h40, 7'h64, 7'h7e, 7'h7f};
    logic [2:0] alt_line[4] = '{3'h1, 3'h3, 3'h2, 3'h0};
    logic [3:0] idle = 4'hc;

    // ==========================================================
    // design and board
    ppsp_pin_select i_dut (.mclk(mclk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .p0_pin_in(p0_lvl), .p0_pin_out(p0_out),
        .p0_pin_oe_n(p0_oe_n), .p1_pin_in(p1_lvl), .p1_pin_out(p1_out),
        .p1_pin_oe_n(p1_oe_n), .p3_pin_in(p3_lvl), .p3_pin_out(p3_out),
        .p3_pin_oe_n(p3_oe_n), .timer_zero_irq_enable(en[0]),
        .timer_one_irq_enable(en[1]), .ext_irq_a_enable(en[2]), .ext_irq_b_enable(en[3]),
        .i2c_scl_drive_low(scl_low), .i2c_sda_drive_low(sda_low), .i2c_scl_in(scl_in),
        .i2c_sda_in(sda_in), .timer_zero_count_input(fo[0]),
        .timer_one_count_input(fo[1]), .ext_irq_a_pin(fo[2]), .ext_irq_b_pin(fo[3]),
        .threshold_input_a(thr[0]), .threshold_input_b(thr[1]), .threshold_input_c(thr[2]));
    ppsp_board #(.W(8)) i_b0 (.pin_out(p0_out), .pin_oe_n(p0_oe_n), .ext_low(p0_ext_low),
        .level(p0_lvl));
    ppsp_board #(.W(4)) i_b1 (.pin_out(p1_out), .pin_oe_n(p1_oe_n), .ext_low(p1_ext_low),
        .level(p1_lvl));
    ppsp_board #(.W(8)) i_b3 (.pin_out(p3_out), .pin_oe_n(p3_oe_n), .ext_low(p3_ext_low),
        .level(p3_lvl));

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge mclk);
        sfr_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] d);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_rmw <= m;
        sfr_rd <= 1'b1;
        @(posedge mclk);
        sfr_rd <= 1'b0;
        #1;
        d = sfr_rdata;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk(16'({p1_oe_n, p0_oe_n}), 16'h0fff, "idle drive");
        rd(`PPSP_ADDR_PORT3, 1'b1, rv);
        chk(16'(rv), 16'h00ff, "port3 latch");
        for (int n = 0; n < 9; n++) begin
            rd(pwm_addr[n], 1'b0, rv);
            chk(16'({sfr_hit, rv}), 16'h0100, "pwm reset");
        end
        rd(8'h81, 1'b0, rv);
        chk(16'({sfr_hit, rv}), 16'h0000, "unmapped");
    endtask

    task automatic t_select();
        wr(`PPSP_ADDR_PORT1_FUNCTION_SELECT, 8'hff);
        rd(`PPSP_ADDR_PORT1_FUNCTION_SELECT, 1'b0, rv);
        chk(16'(rv), 16'h0017, "select mask");
        for (int i = 0; i < 3; i++) begin
            wr(`PPSP_ADDR_PORT1_FUNCTION_SELECT, 8'(1 << i));
            chk(16'(thr), 16'(1 << i), "threshold");
        end
        wr(`PPSP_ADDR_PORT1_FUNCTION_SELECT, 8'h00);
        rd(`PPSP_ADDR_PORT1, 1'b1, rv);
        chk(16'({thr, rv}), 16'h000f, "port1 lines");
    endtask

    task automatic t_i2c();
        wr(`PPSP_ADDR_PORT1_FUNCTION_SELECT, 8'h10);
        sda_low <= 1'b1;
        p3_ext_low <= 8'h10;
        cyc(4);
        chk(16'({p3_lvl[5], sda_in, scl_in}), 16'h0000, "i2c routed");
        wr(`PPSP_ADDR_PORT3, 8'hdf);
        cyc(4);
        chk(16'({sda_in, scl_in}), 16'h0002, "sda latch off");
        wr(`PPSP_ADDR_PORT3, 8'hff);
        wr(`PPSP_ADDR_PORT1_FUNCTION_SELECT, 8'h00);
        cyc(4);
        chk(16'({p3_lvl[5], sda_in, scl_in}), 16'h0007, "i2c off");
        sda_low <= 1'b0;
        p3_ext_low <= 8'h00;
    endtask

    task automatic t_alt();
        logic [2:0] ln;
        for (int k = 0; k < 4; k++) begin
            ln = alt_line[k];
            en <= 4'(1 << k);
            cyc(4);
            chk(16'(fo[k]), 16'h0001, "alt high");
            p3_ext_low <= 8'(1 << ln);
            cyc(4);
            chk(16'(fo[k]), 16'h0000, "alt low");
            p3_ext_low <= 8'({7'h00, idle[k]} << ln);
            en <= 4'h0;
            cyc(4);
            chk(16'(fo[k]), 16'(idle[k]), "enable off");
            en <= 4'(1 << k);
            wr(`PPSP_ADDR_PORT3, 8'hff ^ 8'(1 << ln));
            cyc(4);
            chk(16'(fo[k]), 16'(idle[k]), "latch off");
            wr(`PPSP_ADDR_PORT3, 8'hff);
        end
        en <= 4'hf;
        p3_ext_low <= 8'h40;
        wr(`PPSP_ADDR_PORT3, 8'h7f);
        cyc(4);
        chk(16'({p3_out, p3_oe_n[7:6], p3_lvl[7:6]}), 16'h0004, "plain lines");
        rd(`PPSP_ADDR_PORT3, 1'b0, rv);
        chk(16'(rv[7:6]), 16'h0000, "plain read");
        wr(`PPSP_ADDR_PORT3, 8'hff);
        p3_ext_low <= 8'h00;
        en <= 4'h0;
    endtask

    task automatic t_port0();
        wr(`PPSP_ADDR_PORT0, 8'h5a);
        p0_ext_low <= 8'h02;
        chk(16'(p0_oe_n), 16'h005a, "p0 latch drive");
        cyc(3);
        rd(`PPSP_ADDR_PORT0, 1'b1, rv);
        chk(16'(rv), 16'h005a, "p0 latch read");
        rd(`PPSP_ADDR_PORT0, 1'b0, rv);
        chk(16'(rv), 16'h0058, "p0 pin read");
        wr(`PPSP_ADDR_PORT0, 8'hff);
        p0_ext_low <= 8'h00;
    endtask

    task automatic t_pwm();
        for (int n = 0; n < 9; n++) begin
            wr(pwm_addr[n], {1'b1, duty[n]});
            rd(pwm_addr[n], 1'b0, rv);
            chk(16'(rv), 16'({1'b1, duty[n]}), "pwm reg");
            hi[n] = 16'h0000;
        end
        cyc(600);
        chk(16'({p1_oe_n[3], p0_oe_n}), 16'h0000, "pwm drive");
        for (int c = 0; c < `PPSP_PWM_PERIOD * `PPSP_PWM_DIV; c++) begin
            hi[0] += 16'(p1_lvl[3]);
            for (int n = 1; n < 9; n++) begin
                hi[n] += 16'(p0_lvl[n-1]);
            end
            cyc(1);
        end
        for (int n = 0; n < 9; n++) begin
            chk(hi[n], 16'(duty[n] * `PPSP_PWM_DIV), "high time");
        end
        wr(pwm_addr[0], {1'b0, duty[8]});
        chk(16'({p1_oe_n[3], p0_oe_n}), 16'h0100, "pwm_level_0 off");
        for (int n = 1; n < 9; n++) begin
            wr(pwm_addr[n], {1'b0, duty[n]});
        end
        chk(16'(p0_oe_n), 16'h00ff, "pwm off");
    endtask

    // ==========================================================
    // clock, watchdog and main sequence
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        repeat (100000) @(posedge mclk);
        n_fail++;
        close_out();
    end

    initial begin
        sys_rst = 1'b1;
        {sfr_wr, sfr_rd, sfr_rmw, scl_low, sda_low} = 5'h00;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        {p0_ext_low, p3_ext_low, p1_ext_low, en} = 24'h000000;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        #1;
        t_reset();
        t_select();
        t_i2c();
        t_alt();
        t_port0();
        t_pwm();
        close_out();
    end
endmodule // tb_top
